// file: logic/sbfch_config_header.sv
`timescale 1ns/100ps
`default_nettype none
module sbfch_config_header (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Configuration access port for this function.
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [5:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // Command register bits held elsewhere in the function.
    input wire logic memory_response_enable,
    input wire logic invalidate_write_enable,
    // Memory target decode.
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic window_hit,
    output logic [10:0] window_offset,
    // Initiator side.
    input wire logic init_frame_start,
    input wire logic init_busy,
    input wire logic init_req,
    input wire logic [1:0] init_op,
    input wire logic gnt_n,
    output logic [3:0] init_cmd,
    output logic init_cmd_valid,
    output logic tenure_end,
    output logic latency_expired,
    // Programmed values for the transfer engine.
    output logic [7:0] line_size_setting,
    output logic [7:0] latency_setting
);
    typedef struct packed {
        logic [7:0] latency;
        logic [7:0] line_size;
        logic [20:0] window_base_pointer;
        logic [31:0] rdata;
        logic ack;
        logic gnt_meta;
        logic gnt_sync;
        logic hit;
        logic [10:0] offset;
        logic [3:0] cmd;
        logic cmd_valid;
    } sbfch_state_t;

    sbfch_state_t st_reg;
    sbfch_state_t st_next;

    logic [31:0] class_word;
    logic [31:0] latline_word;
    logic [31:0] base_word;
    logic [31:0] read_word;
    logic cfg_write;
    logic grant_held;
    logic timer_expired;
    logic timer_end;

    // Fixed identity fields; nothing in the write path reaches them.
    assign class_word = {sbfch_pkg::SBFCH_FUNCTION_CATEGORY,
                         sbfch_pkg::SBFCH_FUNCTION_SUBCATEGORY,
                         sbfch_pkg::SBFCH_PROGRAMMING_MODEL,
                         sbfch_pkg::SBFCH_SILICON_REVISION};

    // Dword 03h: header layout and self-test in the upper half.
    assign latline_word = {sbfch_pkg::SBFCH_SELF_TEST,
                           sbfch_pkg::SBFCH_HEADER_LAYOUT,
                           st_reg.latency,
                           st_reg.line_size};

    // Low bits are constant, so an all-ones probe reads back the window size.
    assign base_word = {st_reg.window_base_pointer,
                        sbfch_pkg::SBFCH_WINDOW_SIZE,
                        sbfch_pkg::SBFCH_PREFETCH,
                        sbfch_pkg::SBFCH_LOCATOR_TYPE,
                        sbfch_pkg::SBFCH_SPACE};

    // Read multiplexer; unmapped dwords read as zero.
    always_comb begin
        read_word = 32'h00000000;
        case (cfg_addr)
            sbfch_pkg::SBFCH_IDX_CLASS: begin
                read_word = class_word;
            end
            sbfch_pkg::SBFCH_IDX_LATLINE: begin
                read_word = latline_word;
            end
            sbfch_pkg::SBFCH_IDX_BASE: begin
                read_word = base_word;
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

    assign cfg_write = cfg_sel && cfg_wr;
    // The second synchroniser stage is the only reader of the first.
    assign grant_held = !st_reg.gnt_sync;

    // Next-state logic for every register of the block.
    always_comb begin
        st_next = st_reg;
        st_next.gnt_meta = gnt_n;
        st_next.gnt_sync = st_reg.gnt_meta;
        st_next.ack = cfg_sel;
        st_next.cmd_valid = init_req;

        // Each access is answered one cycle later; lanes not enabled read zero.
        if (cfg_sel && !cfg_wr) begin
            st_next.rdata = read_word & {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                                         {8{cfg_be[1]}}, {8{cfg_be[0]}}};
        end else begin
            st_next.rdata = 32'h00000000;
        end

        // Writable bytes follow their lane enables; read-only lanes are dropped.
        if (cfg_write && (cfg_addr == sbfch_pkg::SBFCH_IDX_LATLINE)) begin
            if (cfg_be[0]) begin
                st_next.line_size = cfg_wdata[7:0];
            end
            if (cfg_be[1]) begin
                st_next.latency = cfg_wdata[15:8];
            end
        end
        if (cfg_write && (cfg_addr == sbfch_pkg::SBFCH_IDX_BASE)) begin
            if (cfg_be[1]) begin
                st_next.window_base_pointer[4:0] = cfg_wdata[15:11];
            end
            if (cfg_be[2]) begin
                st_next.window_base_pointer[12:5] = cfg_wdata[23:16];
            end
            if (cfg_be[3]) begin
                st_next.window_base_pointer[20:13] = cfg_wdata[31:24];
            end
        end

        // Window claim; a disabled memory response leaves the access unclaimed.
        st_next.hit = mem_req && memory_response_enable &&
                      (mem_addr[31:sbfch_pkg::SBFCH_BASE_PTR_LSB] ==
                       st_reg.window_base_pointer);
        if (mem_req) begin
            st_next.offset = mem_addr[10:0];
        end

        // Command choice; line commands need a programmed line size.
        case (init_op)
            sbfch_pkg::SBFCH_OP_WRITE: begin
                if (invalidate_write_enable && (st_reg.line_size != 8'h00)) begin
                    st_next.cmd = sbfch_pkg::SBFCH_CMD_INVAL_WRITE;
                end else begin
                    st_next.cmd = sbfch_pkg::SBFCH_CMD_MEM_WRITE;
                end
            end
            sbfch_pkg::SBFCH_OP_READ_LINE: begin
                if (st_reg.line_size != 8'h00) begin
                    st_next.cmd = sbfch_pkg::SBFCH_CMD_READ_LINE;
                end else begin
                    st_next.cmd = sbfch_pkg::SBFCH_CMD_MEM_READ;
                end
            end
            sbfch_pkg::SBFCH_OP_READ_MULTIPLE: begin
                if (st_reg.line_size != 8'h00) begin
                    st_next.cmd = sbfch_pkg::SBFCH_CMD_READ_MULTIPLE;
                end else begin
                    st_next.cmd = sbfch_pkg::SBFCH_CMD_MEM_READ;
                end
            end
            default: begin
                st_next.cmd = sbfch_pkg::SBFCH_CMD_MEM_READ;
            end
        endcase
        if (!init_req) begin
            st_next.cmd = st_reg.cmd;
        end
    end

    // State register; the grant pin resets to its idle (deasserted) level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg.latency <= sbfch_pkg::SBFCH_LATENCY_RESET;
            st_reg.line_size <= sbfch_pkg::SBFCH_LINE_SIZE_RESET;
            st_reg.window_base_pointer <= sbfch_pkg::SBFCH_BASE_RESET;
            st_reg.rdata <= 32'h00000000;
            st_reg.ack <= 1'b0;
            st_reg.gnt_meta <= 1'b1;
            st_reg.gnt_sync <= 1'b1;
            st_reg.hit <= 1'b0;
            st_reg.offset <= 11'h000;
            st_reg.cmd <= sbfch_pkg::SBFCH_CMD_MEM_READ;
            st_reg.cmd_valid <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus tenure limit, counted in clock cycles of this domain.
    sbfch_tenure_timer u_tenure_timer (
        .mclk(mclk),
        .rst(rst),
        .latency_value(st_reg.latency),
        .frame_start(init_frame_start),
        .busy(init_busy),
        .grant_held(grant_held),
        .expired(timer_expired),
        .tenure_end(timer_end)
    );

    // Outputs.
    assign cfg_ack = st_reg.ack;
    assign cfg_rdata = st_reg.rdata;
    assign window_hit = st_reg.hit;
    assign window_offset = st_reg.offset;
    assign init_cmd = st_reg.cmd;
    assign init_cmd_valid = st_reg.cmd_valid;
    assign tenure_end = timer_end;
    assign latency_expired = timer_expired;
    assign line_size_setting = st_reg.line_size;
    assign latency_setting = st_reg.latency;
endmodule
`default_nettype wire

// file: inc/sbfch_pkg.sv
`default_nettype none
package sbfch_pkg;
    // Configuration dword indices (byte offset divided by four).
    localparam logic [5:0] SBFCH_IDX_CLASS = 6'h02;
    localparam logic [5:0] SBFCH_IDX_LATLINE = 6'h03;
    localparam logic [5:0] SBFCH_IDX_BASE = 6'h04;
    // Printed byte offsets; the header layout byte is byte 2 (bits 23:16) of dword 03h, below self-test.
    localparam logic [7:0] SBFCH_OFS_CLASS = 8'h08;
    localparam logic [7:0] SBFCH_OFS_LATLINE = 8'h0C;
    localparam logic [7:0] SBFCH_OFS_HDR = 8'h0E;
    localparam logic [7:0] SBFCH_OFS_BASE = 8'h10;
    // Fixed class word fields.
    localparam logic [7:0] SBFCH_FUNCTION_CATEGORY = 8'h0C;
    localparam logic [7:0] SBFCH_FUNCTION_SUBCATEGORY = 8'h00;
    localparam logic [7:0] SBFCH_PROGRAMMING_MODEL = 8'h10;
    // Arbitrary silicon revision value.
    localparam logic [7:0] SBFCH_SILICON_REVISION = 8'h5A;
    // Header layout and self-test bytes.
    localparam logic [7:0] SBFCH_SELF_TEST = 8'h00;
    localparam logic [7:0] SBFCH_HEADER_LAYOUT = 8'h00;
    // Window base register layout.
    localparam int SBFCH_BASE_PTR_LSB = 11;
    localparam int SBFCH_BASE_PTR_W = 21;
    localparam logic [6:0] SBFCH_WINDOW_SIZE = 7'h00;
    localparam logic SBFCH_PREFETCH = 1'b0;
    localparam logic [1:0] SBFCH_LOCATOR_TYPE = 2'h0;
    localparam logic SBFCH_SPACE = 1'b0;
    // Reset values.
    localparam logic [7:0] SBFCH_LATENCY_RESET = 8'h00;
    localparam logic [7:0] SBFCH_LINE_SIZE_RESET = 8'h00;
    localparam logic [20:0] SBFCH_BASE_RESET = 21'h000000;
    // Bus command encodings driven onto C/BE during the address phase.
    localparam logic [3:0] SBFCH_CMD_MEM_READ = 4'h6;
    localparam logic [3:0] SBFCH_CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] SBFCH_CMD_READ_MULTIPLE = 4'hC;
    localparam logic [3:0] SBFCH_CMD_READ_LINE = 4'hE;
    localparam logic [3:0] SBFCH_CMD_INVAL_WRITE = 4'hF;
    // Initiator operation requests from the transfer engine.
    localparam logic [1:0] SBFCH_OP_WRITE = 2'h0;
    localparam logic [1:0] SBFCH_OP_READ = 2'h1;
    localparam logic [1:0] SBFCH_OP_READ_LINE = 2'h2;
    localparam logic [1:0] SBFCH_OP_READ_MULTIPLE = 2'h3;
    // Latency timer states.
    typedef enum logic [1:0] {
        SBFCH_TMR_IDLE,
        SBFCH_TMR_COUNT,
        SBFCH_TMR_EXPIRED
    } sbfch_tmr_state_t;
endpackage
`default_nettype wire

// file: logic/sbfch_tenure_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sbfch_tenure_timer (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Programmed limit.
    input wire logic [7:0] latency_value,
    // Initiator activity.
    input wire logic frame_start,
    input wire logic busy,
    input wire logic grant_held,
    // Results.
    output logic expired,
    output logic tenure_end
);
    typedef struct packed {
        sbfch_pkg::sbfch_tmr_state_t state;
        logic [7:0] count;
        logic tenure_end;
    } sbfch_tmr_t;

    sbfch_tmr_t tmr_reg;
    sbfch_tmr_t tmr_next;

    // The count restarts from zero on every FRAME, even mid-tenure.
    always_comb begin
        tmr_next = tmr_reg;
        tmr_next.tenure_end = 1'b0;
        case (tmr_reg.state)
            sbfch_pkg::SBFCH_TMR_IDLE: begin
                tmr_next.count = 8'h00;
            end
            sbfch_pkg::SBFCH_TMR_COUNT: begin
                if (!busy) begin
                    tmr_next.state = sbfch_pkg::SBFCH_TMR_IDLE;
                end else if (tmr_reg.count == latency_value) begin
                    tmr_next.state = sbfch_pkg::SBFCH_TMR_EXPIRED;
                end else begin
                    tmr_next.count = tmr_reg.count + 8'h01;
                end
            end
            sbfch_pkg::SBFCH_TMR_EXPIRED: begin
                // A held grant lets the burst run on past the limit.
                if (!busy) begin
                    tmr_next.state = sbfch_pkg::SBFCH_TMR_IDLE;
                end else begin
                    tmr_next.tenure_end = !grant_held;
                end
            end
            default: begin
                tmr_next.state = sbfch_pkg::SBFCH_TMR_IDLE;
            end
        endcase
        if (frame_start) begin
            tmr_next.state = sbfch_pkg::SBFCH_TMR_COUNT;
            tmr_next.count = 8'h00;
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tmr_reg.state <= sbfch_pkg::SBFCH_TMR_IDLE;
            tmr_reg.count <= 8'h00;
            tmr_reg.tenure_end <= 1'b0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign expired = (tmr_reg.state == sbfch_pkg::SBFCH_TMR_EXPIRED);
    assign tenure_end = tmr_reg.tenure_end;
endmodule
`default_nettype wire

// file: verif/sbfch_config_header_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sbfch_config_header_sva (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Configuration port.
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [5:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // Decode and command side.
    input wire logic memory_response_enable,
    input wire logic invalidate_write_enable,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic window_hit,
    input wire logic [10:0] window_offset,
    input wire logic init_frame_start,
    input wire logic init_req,
    input wire logic [1:0] init_op,
    input wire logic gnt_n,
    input wire logic [3:0] init_cmd,
    input wire logic tenure_end,
    input wire logic latency_expired,
    input wire logic [7:0] line_size_setting,
    input wire logic [7:0] latency_setting
);
    // All checks share mclk and sleep through reset.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // A read request, decoded once since three checks start from it.
    logic rd_q;
    assign rd_q = cfg_sel && !cfg_wr;
    AST_ACK: assert property (cfg_sel |=> cfg_ack)
        else $error("config access not acknowledged");
    AST_CLASS: assert property (
        rd_q && cfg_be == 4'hF && cfg_addr == sbfch_pkg::SBFCH_IDX_CLASS
        |=> cfg_rdata == {8'h0C, 8'h00, 8'h10, sbfch_pkg::SBFCH_SILICON_REVISION})
        else $error("class word wrong");
    AST_HDR: assert property (
        rd_q && cfg_addr == sbfch_pkg::SBFCH_IDX_LATLINE |=> cfg_rdata[31:16] == 16'h0000)
        else $error("header or self-test byte not zero");
    AST_BASE_LOW: assert property (
        rd_q && cfg_addr == sbfch_pkg::SBFCH_IDX_BASE |=> cfg_rdata[10:0] == 11'h000)
        else $error("window base low bits not zero");
    AST_LAT_SET: assert property (
        cfg_sel && cfg_wr && cfg_addr == sbfch_pkg::SBFCH_IDX_LATLINE && cfg_be[1]
        |=> {16'h0000, latency_setting, 8'h00} == ($past(cfg_wdata) & 32'h0000FF00))
        else $error("latency byte not stored");
    AST_LINE_SET: assert property (
        cfg_sel && cfg_wr && cfg_addr == sbfch_pkg::SBFCH_IDX_LATLINE && cfg_be[0]
        |=> {24'h000000, line_size_setting} == ($past(cfg_wdata) & 32'h000000FF))
        else $error("line size not stored");
    AST_HIT_OFF: assert property (mem_req && !memory_response_enable |=> !window_hit)
        else $error("window hit while memory response disabled");
    AST_OFFSET: assert property (
        mem_req |=> {21'h000000, window_offset} == ($past(mem_addr) & 32'h000007FF))
        else $error("window offset not captured");
    AST_PLAIN_WR: assert property (
        init_req && init_op == sbfch_pkg::SBFCH_OP_WRITE && !invalidate_write_enable
        |=> init_cmd == sbfch_pkg::SBFCH_CMD_MEM_WRITE)
        else $error("invalidate write issued while disabled");
    AST_LINE_RD: assert property (
        init_req && init_op == sbfch_pkg::SBFCH_OP_READ_LINE && line_size_setting != 8'h00
        |=> init_cmd == sbfch_pkg::SBFCH_CMD_READ_LINE)
        else $error("read line command wrong");
    AST_FRAME: assert property (init_frame_start |=> !latency_expired)
        else $error("latency count not restarted on frame");
    AST_TENURE: assert property (
        tenure_end |-> $past(gnt_n, 3) && $past(latency_expired))
        else $error("tenure ended without expiry and grant loss");
    // Main scenarios seen.
    cover property (tenure_end);
    cover property (window_hit);
    cover property (init_req && invalidate_write_enable && init_op == sbfch_pkg::SBFCH_OP_WRITE);
endmodule
bind sbfch_config_header sbfch_config_header_sva sva_u (.mclk, .rst, .cfg_sel, .cfg_wr, .cfg_addr,
    .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .memory_response_enable, .invalidate_write_enable,
    .mem_req, .mem_addr, .window_hit, .window_offset, .init_frame_start, .init_req, .init_op,
    .gnt_n, .init_cmd, .tenure_end, .latency_expired, .line_size_setting, .latency_setting);
`default_nettype wire

// file: verif/sbfch_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbfch_host_model (
    // Clock.
    input wire logic mclk,
    // Request to the function.
    output logic cfg_sel,
    output logic cfg_wr,
    output logic [5:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // Answer.
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    // Idle start; qualifiers are junk until a request drives them.
    initial begin
        cfg_sel = 1'b0;
        cfg_wr = 1'b1;
        cfg_addr = 6'h3F;
        cfg_be = 4'hF;
        cfg_wdata = 32'hA5A5A5A5;
    end
    // One-cycle access; released lines flip so stale values never pass for data.
    task automatic access(input logic wr, input logic [5:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] q, output logic ack);
        @(posedge mclk);
        #1;
        cfg_sel = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge mclk);
        #1;
        ack = cfg_ack;
        q = cfg_rdata;
        cfg_sel = 1'b0;
        cfg_addr = ~a;
        cfg_be = ~be;
        cfg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// file: verif/sbfch_config_header_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sbfch_config_header_tb;
    logic mclk, rst, cfg_sel, cfg_wr, cfg_ack, mre, iwe, mem_req, window_hit;
    logic [5:0] cfg_addr;
    logic [3:0] cfg_be, init_cmd;
    logic [31:0] cfg_wdata, cfg_rdata, mem_addr;
    logic [10:0] window_offset;
    logic frame, busy, init_req, gnt_n, valid, tenure_end, expired;
    logic [1:0] init_op;
    logic [7:0] line_size, latency;
    int fails, comparisons, cycles;
    // Class word as the rules fix it; only the revision byte is ours to choose.
    localparam logic [31:0] class_exp = {24'h0C0010, sbfch_pkg::SBFCH_SILICON_REVISION};
    sbfch_config_header dut_u (.mclk(mclk), .rst(rst), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .memory_response_enable(mre), .invalidate_write_enable(iwe),
        .mem_req(mem_req), .mem_addr(mem_addr), .window_hit(window_hit),
        .window_offset(window_offset), .init_frame_start(frame), .init_busy(busy),
        .init_req(init_req), .init_op(init_op), .gnt_n(gnt_n), .init_cmd(init_cmd),
        .init_cmd_valid(valid), .tenure_end(tenure_end), .latency_expired(expired),
        .line_size_setting(line_size), .latency_setting(latency));
    sbfch_host_model host_u (.mclk(mclk), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata));
    // Free-running 250 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // A hung handshake must not stall the run forever.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_word({31'h0, got}, {31'h0, exp}, m);
    endtask
    task automatic rd(input logic [5:0] a, input logic [3:0] be, input logic [31:0] exp);
        logic [31:0] q;
        logic k;
        host_u.access(1'b0, a, be, 32'h00000000, q, k);
        chk_bit(k, 1'b1, "read ack");
        chk_word(q, exp, "read data");
    endtask
    task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic k;
        host_u.access(1'b1, a, be, d, q, k);
        chk_bit(k, 1'b1, "write ack");
    endtask
    // One decode request; the enable level is set with it and left standing.
    task automatic mem(input logic [31:0] a, input logic en, input logic hit);
        @(posedge mclk);
        #1;
        mre = en;
        mem_req = 1'b1;
        mem_addr = a;
        @(posedge mclk);
        #1;
        mem_req = 1'b0;
        mem_addr = ~a;
        chk_bit(window_hit, hit, "window hit");
        chk_word({21'h0, window_offset}, a & 32'h000007FF, "window offset");
    endtask
    task automatic cmd(input logic [1:0] op, input logic [3:0] exp);
        @(posedge mclk);
        #1;
        init_req = 1'b1;
        init_op = op;
        @(posedge mclk);
        #1;
        init_req = 1'b0;
        chk_bit(valid, 1'b1, "command valid");
        chk_word({28'h0, init_cmd}, {28'h0, exp}, "command code");
    endtask
    // Main sequence; the latency byte is set to 4 before the tenure test.
    initial begin
        {rst, mre, iwe, mem_req, frame, busy, init_req, gnt_n} = 8'h80;
        mem_addr = 32'h00000000;
        init_op = 2'h0;
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        rd(sbfch_pkg::SBFCH_IDX_LATLINE, 4'hF, 32'h00000000);
        rd(sbfch_pkg::SBFCH_IDX_BASE, 4'hF, 32'h00000000);
        wr(sbfch_pkg::SBFCH_IDX_CLASS, 4'hF, 32'hFFFFFFFF);
        rd(sbfch_pkg::SBFCH_IDX_CLASS, 4'hF, class_exp);
        rd(sbfch_pkg::SBFCH_IDX_CLASS, 4'h3, class_exp & 32'h0000FFFF);
        wr(sbfch_pkg::SBFCH_IDX_LATLINE, 4'hF, 32'hFFFFFFFF);
        rd(sbfch_pkg::SBFCH_IDX_LATLINE, 4'hF, 32'h0000FFFF);
        chk_word({24'h0, line_size}, 32'h000000FF, "line size");
        chk_word({24'h0, latency}, 32'h000000FF, "latency");
        wr(sbfch_pkg::SBFCH_IDX_BASE, 4'hF, 32'hFFFFFFFF);
        rd(sbfch_pkg::SBFCH_IDX_BASE, 4'hF, 32'hFFFFF800);
        wr(sbfch_pkg::SBFCH_IDX_BASE, 4'hF, 32'h12345678);
        wr(sbfch_pkg::SBFCH_IDX_BASE, 4'h8, 32'hAB000000);
        rd(sbfch_pkg::SBFCH_IDX_BASE, 4'hF, 32'hAB345000);
        rd(sbfch_pkg::SBFCH_IDX_BASE, 4'h3, 32'h00005000);
        wr(6'h05, 4'hF, 32'hFFFFFFFF);
        rd(6'h05, 4'hF, 32'h00000000);
        mem(32'hAB345010, 1'b0, 1'b0);
        mem(32'hAB345010, 1'b1, 1'b1);
        mem(32'hAB345810, 1'b1, 1'b0);
        iwe = 1'b1;
        cmd(sbfch_pkg::SBFCH_OP_WRITE, sbfch_pkg::SBFCH_CMD_INVAL_WRITE);
        iwe = 1'b0;
        cmd(sbfch_pkg::SBFCH_OP_WRITE, sbfch_pkg::SBFCH_CMD_MEM_WRITE);
        cmd(sbfch_pkg::SBFCH_OP_READ, sbfch_pkg::SBFCH_CMD_MEM_READ);
        cmd(sbfch_pkg::SBFCH_OP_READ_LINE, sbfch_pkg::SBFCH_CMD_READ_LINE);
        cmd(sbfch_pkg::SBFCH_OP_READ_MULTIPLE, sbfch_pkg::SBFCH_CMD_READ_MULTIPLE);
        wr(sbfch_pkg::SBFCH_IDX_LATLINE, 4'h3, 32'h00000400);
        iwe = 1'b1;
        cmd(sbfch_pkg::SBFCH_OP_WRITE, sbfch_pkg::SBFCH_CMD_MEM_WRITE);
        cmd(sbfch_pkg::SBFCH_OP_READ_MULTIPLE, sbfch_pkg::SBFCH_CMD_MEM_READ);
        @(posedge mclk);
        #1 {frame, busy} = 2'b11;
        @(posedge mclk);
        #1 frame = 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk_bit(expired, 1'b0, "early expiry");
        @(posedge mclk);
        #1 chk_bit(expired, 1'b1, "expiry");
        repeat (4) @(posedge mclk);
        #1 chk_bit(tenure_end, 1'b0, "tenure with grant");
        gnt_n = 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk_bit(tenure_end, 1'b0, "tenure too soon");
        @(posedge mclk);
        #1 chk_bit(tenure_end, 1'b1, "tenure end");
        frame = 1'b1;
        @(posedge mclk);
        #1 frame = 1'b0;
        chk_bit(expired, 1'b0, "restart");
        {busy, gnt_n} = 2'b00;
        repeat (2) @(posedge mclk);
        #1 chk_bit(expired, 1'b0, "idle");
        close_out();
    end
endmodule
`default_nettype wire
